// ### uxr_pkg.sv
package uxr_pkg;

   // register indices on the three-bit host address
   localparam logic [2:0] A_DIV_LOW   = 3'h0;
   localparam logic [2:0] A_DIV_HIGH  = 3'h1;
   localparam logic [2:0] A_INT_EN    = 3'h1;
   localparam logic [2:0] A_INT_STAT  = 3'h2;
   localparam logic [2:0] A_FEATURE   = 3'h2;
   localparam logic [2:0] A_TX_FREE   = 3'h3;
   localparam logic [2:0] A_PAUSE_1   = 3'h3;
   localparam logic [2:0] A_MODEM_CTL = 3'h4;
   localparam logic [2:0] A_RESUME_1  = 3'h4;
   localparam logic [2:0] A_RX_FILL   = 3'h5;
   localparam logic [2:0] A_RESUME_2  = 3'h5;
   localparam logic [2:0] A_BANK_SEL  = 3'h6;
   localparam logic [2:0] A_SCRATCH   = 3'h7;
   localparam logic [2:0] A_PAUSE_2   = 3'h7;

   // bank field codes
   localparam logic [1:0] BANK_GEN    = 2'h0;
   localparam logic [1:0] BANK_EXT1   = 2'h1;
   localparam logic [1:0] BANK_EXT2   = 2'h2;

   // field positions
   localparam int BS_CNT_EN   = 0;
   localparam int EF_AUTO_CTS = 7;
   localparam int EF_AUTO_RTS = 6;
   localparam int EF_SPECIAL  = 5;
   localparam int EF_ENHANCED = 4;
   localparam int MC_RTS      = 1;

   // reset values and sizes
   localparam logic [7:0]  BYTE_RST   = 8'h00;
   localparam logic [7:0]  FIFO_DEPTH = 8'h80;
   localparam logic [14:0] PIN_IDLE   = 15'h7fff;

   // the four flow-control characters
   typedef struct packed {
      logic [7:0] resume_first;
      logic [7:0] resume_second;
      logic [7:0] pause_first;
      logic [7:0] pause_second;
   } uxr_chars_t;

   // host pins after synchronisation
   typedef struct packed {
      logic       cts_n;
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic [2:0] addr;
      logic [7:0] data;
   } uxr_pins_t;

endpackage

// ### uxr_flow_chars.sv
`timescale 1ns/100ps
module uxr_flow_chars
   import uxr_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic [3:0]       flow_sel,
   input  wire uxr_pkg::uxr_chars_t chars,
   input  wire logic             rx_valid,
   input  wire logic [7:0]       rx_char,
   input  wire logic             send_resume,
   input  wire logic             send_pause,
   input  wire logic             tx_ready,
   output logic                  tx_valid,
   output logic [7:0]            tx_char,
   output logic                  rx_resume_det,
   output logic                  rx_pause_det
);
   typedef enum logic [1:0] {TX_IDLE, TX_PAIR, TX_LAST} uxr_tx_st_t;

   uxr_tx_st_t state_reg;
   logic       pause_reg;
   logic [7:0] char_reg;
   logic       half_res_reg;
   logic       half_pau_reg;

   // pick first or second character of the resume or pause pair
   function automatic logic [7:0] pick(input uxr_chars_t c,
                                       input logic pau,
                                       input logic second);
      pick = pau ? (second ? c.pause_second : c.pause_first)
                 : (second ? c.resume_second : c.resume_first);
   endfunction

   // transmit and receive selections
   wire [1:0] tx_sel  = flow_sel[3:2];
   wire [1:0] rx_sel  = flow_sel[1:0];
   wire       req     = send_resume | send_pause;
   wire       rx_pair = (rx_sel == 2'h3) && (tx_sel == 2'h3);

   // exact byte compares, bit 0 against the received lsb
   wire m_r1 = rx_valid && (rx_char == chars.resume_first);
   wire m_r2 = rx_valid && (rx_char == chars.resume_second);
   wire m_p1 = rx_valid && (rx_char == chars.pause_first);
   wire m_p2 = rx_valid && (rx_char == chars.pause_second);

   // single-character match per receive selection
   wire one_res = (rx_sel == 2'h2) ? m_r1 :
                  (rx_sel == 2'h1) ? m_r2 :
                  (rx_sel == 2'h3) ? (m_r1 | m_r2) : 1'b0;
   wire one_pau = (rx_sel == 2'h2) ? m_p1 :
                  (rx_sel == 2'h1) ? m_p2 :
                  (rx_sel == 2'h3) ? (m_p1 | m_p2) : 1'b0;

   assign tx_valid = (state_reg != TX_IDLE);
   assign tx_char  = char_reg;

   // transmit one or two flow characters in order
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= TX_IDLE;
         pause_reg <= 1'b0;
         char_reg  <= BYTE_RST;
      end else begin
         case (state_reg)
            TX_IDLE: begin
               if (req && tx_sel != 2'h0) begin
                  pause_reg <= send_pause;
                  char_reg  <= pick(chars, send_pause, tx_sel == 2'h1);
                  state_reg <= (tx_sel == 2'h3) ? TX_PAIR : TX_LAST;
               end
            end
            TX_PAIR: begin
               if (tx_ready) begin
                  char_reg  <= pick(chars, pause_reg, 1'b1);
                  state_reg <= TX_LAST;
               end
            end
            TX_LAST: begin
               if (tx_ready) begin
                  state_reg <= TX_IDLE;
               end
            end
            default: state_reg <= TX_IDLE;
         endcase
      end
   end

   // receive detection, pairs must arrive back to back
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         half_res_reg  <= 1'b0;
         half_pau_reg  <= 1'b0;
         rx_resume_det <= 1'b0;
         rx_pause_det  <= 1'b0;
      end else begin
         if (rx_valid) begin
            half_res_reg <= rx_pair && m_r1;
            half_pau_reg <= rx_pair && m_p1;
         end
         rx_resume_det <= rx_pair ? (half_res_reg && m_r2) : one_res;
         rx_pause_det  <= rx_pair ? (half_pau_reg && m_p2) : one_pau;
      end
   end

endmodule // uxr_flow_chars

// ### uxr_ext_regs.sv
`timescale 1ns/100ps
//Contract
// - bank select is write-only; its address never returns its contents
// - bank field: 00 general, 01 first extended, 10 second, 11 reserved
// - counter-enable bit 1 makes both level counters readable, 0 hides
// - bank field wins: counters readable only while bank field is zero
// - scratch byte stores eight written bits and reads them back
// - low and high divisor latches form the sixteen-bit baud divisor
// - transmit counter reads free byte spaces of transmit fifo
// - receive counter reads characters held in receive fifo
// - auto cts set: transmitter halts while cts high, resumes when low
// - auto rts: event at trigger level, rts high above, low below trigger minus one
// - without hardware flow control rts follows its software bit
// - special detect compares each char with second pause char, sets flag
// - bit 0 of flow characters aligns with received character lsb
// - enhanced control bits accept writes only while enhanced bit set
// - low four feature bits pick software flow mode, reset to zero
// - dual-character modes send or match the two bytes in order
// - upper flow bits pick transmit chars, lower pick receive compares
// - bank select shares address with modem status: write bank, read
module uxr_ext_regs
   import uxr_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       host_cs_n,
   input  wire logic       host_rd_n,
   input  wire logic       host_wr_n,
   input  wire logic [2:0] host_addr,
   input  wire logic [7:0] host_data_in,
   output logic [7:0]      host_data_out,
   output logic            host_data_oe,
   input  wire logic [7:0] ext_rdata,
   input  wire logic [7:0] tx_fifo_fill,
   input  wire logic [7:0] rx_fifo_fill,
   input  wire logic [7:0] rx_trig_level,
   input  wire logic       rx_char_valid,
   input  wire logic [7:0] rx_char,
   input  wire logic       send_resume,
   input  wire logic       send_pause,
   input  wire logic       tx_flow_ready,
   input  wire logic       cts_n_pin,
   output logic [15:0]     baud_divisor,
   output logic [7:0]      feature_ctl,
   output logic [1:0]      bank_field,
   output logic [3:0]      int_en_hi,
   output logic [1:0]      fifo_ctl_hi,
   output logic [2:0]      modem_ctl_hi,
   output logic            special_char_flag,
   output logic            tx_halt,
   output logic            rts_n_pin,
   output logic            rts_trig_event,
   output logic            tx_flow_valid,
   output logic [7:0]      tx_flow_char,
   output logic            rx_resume_det,
   output logic            rx_pause_det
);

   // ---- pin synchronisers ----
   uxr_pins_t pins_raw;
   uxr_pins_t pins_meta_reg;
   uxr_pins_t pins_reg;

   assign pins_raw = '{cts_n: cts_n_pin, cs_n: host_cs_n,
                       rd_n: host_rd_n, wr_n: host_wr_n,
                       addr: host_addr, data: host_data_in};

   // two flops for every pin before use
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pins_meta_reg <= PIN_IDLE;
         pins_reg      <= PIN_IDLE;
      end else begin
         pins_meta_reg <= pins_raw;
         pins_reg      <= pins_meta_reg;
      end
   end

   // ---- register state ----
   logic [7:0] bank_select_reg;
   logic [7:0] scratch_byte_reg;
   logic [7:0] divisor_low_byte_reg;
   logic [7:0] divisor_high_byte_reg;
   logic [7:0] enhanced_feature_control_reg;
   uxr_chars_t chars_reg;
   logic [3:0] int_en_hi_reg;
   logic [1:0] fifo_ctl_hi_reg;
   logic [2:0] modem_ctl_hi_reg;
   logic       sw_rts_reg;
   logic       spec_reg;
   logic       rd_act_reg;
   logic       wr_act_reg;
   logic [2:0] rd_addr_reg;
   logic [7:0] rdata_reg;
   logic       rts_high_reg;
   logic       at_trig_reg;

   // ---- strobe decode ----
   wire       rd_act = !pins_reg.cs_n && !pins_reg.rd_n;
   wire       wr_act = !pins_reg.cs_n && !pins_reg.wr_n;
   wire       wr_go  = wr_act && !wr_act_reg;
   wire       rd_end = rd_act_reg && !rd_act;
   wire [2:0] wa     = pins_reg.addr;
   wire [7:0] wd     = pins_reg.data;

   // ---- bank and counter gating ----
   wire [1:0] bank   = bank_select_reg[2:1];
   wire       in_gen = (bank == BANK_GEN);
   wire       in_e1  = (bank == BANK_EXT1);
   wire       in_e2  = (bank == BANK_EXT2);
   wire       cnt_ok = in_gen && bank_select_reg[BS_CNT_EN];
   wire       enh_ok = enhanced_feature_control_reg[EF_ENHANCED];

   // ---- write enables, one per target ----
   wire w_bank  = wr_go && (wa == A_BANK_SEL);
   wire w_scr   = wr_go && in_gen && (wa == A_SCRATCH);
   wire w_ie    = wr_go && in_gen && (wa == A_INT_EN);
   wire w_fc    = wr_go && in_gen && (wa == A_INT_STAT);
   wire w_mc    = wr_go && in_gen && (wa == A_MODEM_CTL);
   wire w_dll   = wr_go && in_e1 && (wa == A_DIV_LOW);
   wire w_dlm   = wr_go && in_e1 && (wa == A_DIV_HIGH);
   wire w_efr   = wr_go && in_e2 && (wa == A_FEATURE);
   wire w_res1  = wr_go && in_e2 && (wa == A_RESUME_1);
   wire w_res2  = wr_go && in_e2 && (wa == A_RESUME_2);
   wire w_pau1  = wr_go && in_e2 && (wa == A_PAUSE_1);
   wire w_pau2  = wr_go && in_e2 && (wa == A_PAUSE_2);

   // ---- level counters ----
   wire [7:0] tx_free_space_count = FIFO_DEPTH - tx_fifo_fill;
   wire [7:0] rx_fill_count       = rx_fifo_fill;

   // ---- read selection ----
   wire [7:0] rd_gen =
      (wa == A_SCRATCH)   ? scratch_byte_reg :
      (wa == A_TX_FREE)   ? (cnt_ok ? tx_free_space_count
                                    : ext_rdata) :
      (wa == A_RX_FILL)   ? (cnt_ok ? rx_fill_count
                                    : ext_rdata) :
      (wa == A_INT_EN)    ? {int_en_hi_reg, ext_rdata[3:0]} :
      (wa == A_INT_STAT)  ? {ext_rdata[7:5], spec_reg,
                             ext_rdata[3:0]} :
      (wa == A_MODEM_CTL) ? {modem_ctl_hi_reg, ext_rdata[4:2],
                             sw_rts_reg, ext_rdata[0]} :
      ext_rdata;

   wire [7:0] rd_e1 =
      (wa == A_DIV_LOW)  ? divisor_low_byte_reg :
      (wa == A_DIV_HIGH) ? divisor_high_byte_reg :
      ext_rdata;

   wire [7:0] rd_e2 =
      (wa == A_FEATURE)  ? enhanced_feature_control_reg :
      (wa == A_RESUME_1) ? chars_reg.resume_first :
      (wa == A_RESUME_2) ? chars_reg.resume_second :
      (wa == A_PAUSE_1)  ? chars_reg.pause_first :
      (wa == A_PAUSE_2)  ? chars_reg.pause_second :
      ext_rdata;

   // modem status answers at the shared address in every bank
   wire [7:0] rd_sel =
      (wa == A_BANK_SEL) ? ext_rdata :
      in_gen ? rd_gen :
      in_e1  ? rd_e1 :
      in_e2  ? rd_e2 :
      ext_rdata;

   // read of the interrupt status ends: clear the special flag
   wire stat_rd_done = rd_end && (rd_addr_reg == A_INT_STAT) && in_gen;

   // special character seen on the receive path
   wire spec_hit = enhanced_feature_control_reg[EF_SPECIAL] &&
                   rx_char_valid &&
                   (rx_char == chars_reg.pause_second);

   // ---- bus strobe tracking and read data ----
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rd_act_reg  <= 1'b0;
         wr_act_reg  <= 1'b0;
         rd_addr_reg <= A_DIV_LOW;
         rdata_reg   <= BYTE_RST;
      end else begin
         rd_act_reg <= rd_act;
         wr_act_reg <= wr_act;
         if (rd_act) begin
            rd_addr_reg <= wa;
            rdata_reg   <= rd_sel;
         end
      end
   end

   assign host_data_out = rdata_reg;
   assign host_data_oe  = rd_act_reg;

   // bank selector, written through the modem status address
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bank_select_reg <= BYTE_RST;
      end else if (w_bank) begin
         bank_select_reg <= wd;
      end
   end

   // scratch byte and divisor latches
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         scratch_byte_reg      <= BYTE_RST;
         divisor_low_byte_reg  <= BYTE_RST;
         divisor_high_byte_reg <= BYTE_RST;
      end else begin
         if (w_scr) scratch_byte_reg <= wd;
         if (w_dll) divisor_low_byte_reg <= wd;
         if (w_dlm) divisor_high_byte_reg <= wd;
      end
   end

   assign baud_divisor = {divisor_high_byte_reg,
                          divisor_low_byte_reg};

   // feature register and flow characters
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enhanced_feature_control_reg <= BYTE_RST;
         chars_reg <= '0;
      end else begin
         if (w_efr) enhanced_feature_control_reg <= wd;
         if (w_res1) chars_reg.resume_first <= wd;
         if (w_res2) chars_reg.resume_second <= wd;
         if (w_pau1) chars_reg.pause_first <= wd;
         if (w_pau2) chars_reg.pause_second <= wd;
      end
   end

   assign feature_ctl = enhanced_feature_control_reg;
   assign bank_field  = bank;

   // enhanced control bits, frozen while the enhanced bit is clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         int_en_hi_reg    <= 4'h0;
         fifo_ctl_hi_reg  <= 2'h0;
         modem_ctl_hi_reg <= 3'h0;
         sw_rts_reg       <= 1'b0;
      end else begin
         if (w_ie && enh_ok) int_en_hi_reg <= wd[7:4];
         if (w_fc && enh_ok) fifo_ctl_hi_reg <= wd[5:4];
         if (w_mc && enh_ok) modem_ctl_hi_reg <= wd[7:5];
         if (w_mc) sw_rts_reg <= wd[MC_RTS];
      end
   end

   assign int_en_hi    = int_en_hi_reg;
   assign fifo_ctl_hi  = fifo_ctl_hi_reg;
   assign modem_ctl_hi = modem_ctl_hi_reg;

   // special character flag, a new hit beats the read clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         spec_reg <= 1'b0;
      end else if (spec_hit) begin
         spec_reg <= 1'b1;
      end else if (stat_rd_done) begin
         spec_reg <= 1'b0;
      end
   end

   assign special_char_flag = spec_reg;

   // ---- automatic cts ----
   // pin high means the far end cannot accept data
   assign tx_halt = enhanced_feature_control_reg[EF_AUTO_CTS] &&
                    pins_reg.cts_n;

   // ---- automatic rts thresholds ----
   // a programmed level of zero behaves as one
   wire [8:0] trig   = (rx_trig_level == BYTE_RST) ? 9'h001
                       : {1'b0, rx_trig_level};
   wire [8:0] fill9  = {1'b0, rx_fifo_fill};
   wire       at_trg = fill9 >= trig;
   wire       above  = fill9 >= (trig + 9'h001);
   wire       below  = fill9 < (trig - 9'h001);
   wire       auto_r = enhanced_feature_control_reg[EF_AUTO_RTS];

   // rts hysteresis and the trigger-level event
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rts_high_reg   <= 1'b0;
         at_trig_reg    <= 1'b0;
         rts_trig_event <= 1'b0;
      end else begin
         at_trig_reg    <= at_trg;
         rts_trig_event <= auto_r && at_trg && !at_trig_reg;
         if (!auto_r) begin
            rts_high_reg <= 1'b0;
         end else if (above) begin
            rts_high_reg <= 1'b1;
         end else if (below) begin
            rts_high_reg <= 1'b0;
         end
      end
   end

   // pin is active low: software bit set drives it low
   assign rts_n_pin = auto_r ? rts_high_reg : !sw_rts_reg;

   // ---- software flow characters ----
   // special detect expects the four flow bits cleared by software
   uxr_flow_chars u_flow (
      .core_clk      (core_clk),
      .rst           (rst),
      .flow_sel      (enhanced_feature_control_reg[3:0]),
      .chars         (chars_reg),
      .rx_valid      (rx_char_valid),
      .rx_char       (rx_char),
      .send_resume   (send_resume),
      .send_pause    (send_pause),
      .tx_ready      (tx_flow_ready),
      .tx_valid      (tx_flow_valid),
      .tx_char       (tx_flow_char),
      .rx_resume_det (rx_resume_det),
      .rx_pause_det  (rx_pause_det)
   );

endmodule // uxr_ext_regs

// ### uxr_ext_regs_asserts.sv
`timescale 1ns/100ps
module uxr_ext_regs_chk
   import uxr_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        host_cs_n,
   input wire logic        host_rd_n,
   input wire logic [2:0]  host_addr,
   input wire logic [7:0]  host_data_out,
   input wire logic        host_data_oe,
   input wire logic [7:0]  ext_rdata,
   input wire logic [7:0]  rx_fifo_fill,
   input wire logic [7:0]  rx_trig_level,
   input wire logic        cts_n_pin,
   input wire logic        tx_flow_ready,
   input wire logic [15:0] baud_divisor,
   input wire logic [7:0]  feature_ctl,
   input wire logic [1:0]  bank_field,
   input wire logic [3:0]  int_en_hi,
   input wire logic        tx_halt,
   input wire logic        rts_n_pin,
   input wire logic        rts_trig_event,
   input wire logic        tx_flow_valid,
   input wire logic [7:0]  tx_flow_char
);
   // trigger level as used, zero counts as one
   wire logic [8:0] trig_eff = (rx_trig_level == 8'h00) ? 9'h001
                                                       : {1'b0, rx_trig_level};
   wire logic [8:0] fill9    = {1'b0, rx_fifo_fill};

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // strobe held long enough for the synchroniser
   sequence s_read_held;
      (!host_cs_n && !host_rd_n)[*4];
   endsequence
   sequence s_status_read;
      (!host_cs_n && !host_rd_n && host_addr == A_BANK_SEL
       && $stable(host_addr) && $stable(ext_rdata))[*4];
   endsequence
   sequence s_rts_over;
      (feature_ctl[EF_AUTO_RTS] && fill9 >= trig_eff + 9'h001)[*2];
   endsequence
   sequence s_rts_under;
      (feature_ctl[EF_AUTO_RTS] && fill9 + 9'h001 < trig_eff)[*2];
   endsequence

   chk_oe_read: assert property (
      s_read_held |-> host_data_oe) else $error("oe missing on read");
   chk_oe_idle: assert property (
      host_cs_n[*4] |-> !host_data_oe) else $error("oe while idle");
   chk_bank_read: assert property (
      s_status_read |-> host_data_out == ext_rdata)
      else $error("bank select address returned own contents");
   chk_div_bank: assert property (
      $changed(baud_divisor) |-> bank_field == BANK_EXT1)
      else $error("divisor changed outside first set");
   chk_feat_bank: assert property (
      $changed(feature_ctl) |-> bank_field == BANK_EXT2)
      else $error("feature changed outside second set");
   chk_enh_lock: assert property (
      $changed(int_en_hi) |-> $past(feature_ctl[EF_ENHANCED]))
      else $error("enhanced bits changed while latched");
   chk_halt_cts: assert property (
      (feature_ctl[EF_AUTO_CTS] && cts_n_pin)[*3] |-> tx_halt)
      else $error("no halt with cts high");
   chk_halt_clear: assert property (
      (!cts_n_pin)[*3] |-> !tx_halt) else $error("halt with cts low");
   chk_halt_off: assert property (
      !feature_ctl[EF_AUTO_CTS] |-> !tx_halt)
      else $error("halt without auto cts");
   chk_rts_high: assert property (
      s_rts_over |-> rts_n_pin) else $error("rts not raised");
   chk_rts_low: assert property (
      s_rts_under |-> !rts_n_pin) else $error("rts not lowered");
   chk_trig_event: assert property (
      feature_ctl[EF_AUTO_RTS] && fill9 >= trig_eff
      && $past(fill9 < trig_eff) |=> rts_trig_event)
      else $error("no trigger level event");
   chk_flow_hold: assert property (
      tx_flow_valid && !tx_flow_ready |=> tx_flow_valid
      && $stable(tx_flow_char)) else $error("flow char dropped");
endmodule // uxr_ext_regs_chk

// ### uxr_host_model.sv
`timescale 1ns/100ps
module uxr_host_model
   import uxr_pkg::*;
(
   input  wire logic       core_clk,
   output logic            host_cs_n,
   output logic            host_rd_n,
   output logic            host_wr_n,
   output logic [2:0]      host_addr,
   output logic [7:0]      host_data_in,
   input  wire logic [7:0] host_data_out,
   input  wire logic       host_data_oe
);
   // idle bus, strobes high
   initial begin
      host_cs_n    = 1'b1;
      host_rd_n    = 1'b1;
      host_wr_n    = 1'b1;
      host_addr    = 3'h0;
      host_data_in = 8'h00;
   end

   // write; address and data lead the strobe by 3 cycles and hold 4 cycles after it
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      host_addr    <= a;
      host_data_in <= d;
      repeat (3) @(posedge core_clk);
      host_cs_n <= 1'b0;
      host_wr_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      host_cs_n <= 1'b1;
      host_wr_n <= 1'b1;
      repeat (4) @(posedge core_clk);
      host_data_in <= ~d; // released data shows no stale value
   endtask

   // read; data taken at the edge where oe is seen high
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      host_addr <= a;
      repeat (3) @(posedge core_clk);
      host_cs_n <= 1'b0;
      host_rd_n <= 1'b0;
      do begin
         @(posedge core_clk);
         n++;
      end while (host_data_oe !== 1'b1 && n < 8);
      d = host_data_out;
      host_cs_n <= 1'b1;
      host_rd_n <= 1'b1;
      repeat (4) @(posedge core_clk);
   endtask
endmodule // uxr_host_model

// ### uxr_ext_regs_bench.sv
`timescale 1ns/100ps
module uxr_ext_regs_bench;
   import uxr_pkg::*;
   logic        core_clk, rst, host_cs_n, host_rd_n, host_wr_n;
   logic [2:0]  host_addr;
   logic [7:0]  host_data_in, host_data_out, ext_rdata, tx_fifo_fill;
   logic [7:0]  rx_fifo_fill, rx_trig_level, rx_char, feature_ctl;
   logic [7:0]  tx_flow_char;
   logic        host_data_oe, rx_char_valid, send_resume, send_pause;
   logic        tx_flow_ready, cts_n_pin, special_char_flag, tx_halt;
   logic        rts_n_pin, rts_trig_event, tx_flow_valid;
   logic [15:0] baud_divisor;
   logic [1:0]  bank_field;
   logic [3:0]  int_en_hi;
   logic [2:0]  modem_ctl_hi;
   logic [1:0]  fifo_ctl_hi;
   logic        rx_resume_det, rx_pause_det;
   int unsigned seed = 1463;
   int          err_count = 0;
   int          compares = 0;
   int          cycles = 0;

   uxr_ext_regs DUT (.*);
   uxr_host_model host (.*);

   // clock and hang guard
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         conclude();
      end
   end

   // xorshift source of stimulus
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [7:0] free_of(input logic [7:0] fill);
      return FIFO_DEPTH - fill;
   endfunction

   task automatic cmp(input logic [15:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] e,
                      input string what);
      logic [7:0] d;
      host.rd(a, d);
      cmp(16'(d), 16'(e), what);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic rxc(input logic [7:0] c);
      @(posedge core_clk);
      rx_char_valid <= 1'b1;
      rx_char       <= c;
      @(posedge core_clk);
      rx_char_valid <= 1'b0;
      tick(3);
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // main sequence
   initial begin
      logic [7:0] v, w, e, s;
      logic [7:0] sels [4];
      int         k;
      sels = '{8'h01, 8'h00, 8'h03, 8'h07};
      {rst, ext_rdata, tx_fifo_fill, rx_fifo_fill} = {1'b1, 24'h00_0000};
      {rx_trig_level, rx_char, rx_char_valid} = 17'h0_0000;
      {send_resume, send_pause, tx_flow_ready, cts_n_pin} = 4'h0;
      tick(5);
      rst <= 1'b0;
      tick(2);
      cmp(16'(feature_ctl), 16'h0, "feature reset");
      cmp(16'(bank_field), 16'h0, "bank reset");
      repeat (4) begin
         s = rnd();
         host.wr(A_SCRATCH, s);
         rdc(A_SCRATCH, s, "scratch");
      end
      @(posedge core_clk);
      v = rnd();
      ext_rdata <= v;
      rdc(A_BANK_SEL, v, "bank select read");
      $display("test scratch and select done");
      host.wr(A_BANK_SEL, 8'h02);
      v = rnd();
      w = rnd();
      host.wr(A_DIV_LOW, v);
      host.wr(A_DIV_HIGH, w);
      cmp(baud_divisor, {w, v}, "divisor");
      rdc(A_DIV_HIGH, w, "divisor high");
      for (k = 0; k < 4; k++) begin
         @(posedge core_clk);
         v = rnd() & 8'h7f;
         w = rnd() & 8'h7f;
         e = rnd();
         {tx_fifo_fill, rx_fifo_fill, ext_rdata} <= {v, w, e};
         host.wr(A_BANK_SEL, sels[k]);
         rdc(A_TX_FREE, (k == 0) ? free_of(v) : e, "tx level");
         rdc(A_RX_FILL, (k == 0) ? w : e, "rx level");
      end
      host.wr(A_SCRATCH, ~s);
      host.wr(A_BANK_SEL, 8'h00);
      rdc(A_SCRATCH, s, "reserved bank write");
      $display("test banks done");
      host.wr(A_INT_EN, 8'hf0);
      cmp(16'(int_en_hi), 16'h0, "locked int enable");
      host.wr(A_BANK_SEL, 8'h04);
      host.wr(A_FEATURE, 8'h10);
      host.wr(A_BANK_SEL, 8'h00);
      host.wr(A_INT_EN, 8'ha0);
      host.wr(A_MODEM_CTL, 8'he0);
      cmp(16'({int_en_hi, modem_ctl_hi}), 16'h57, "enhanced");
      host.wr(A_BANK_SEL, 8'h04);
      host.wr(A_FEATURE, 8'h00);
      host.wr(A_BANK_SEL, 8'h00);
      host.wr(A_INT_EN, 8'h50);
      host.wr(A_MODEM_CTL, 8'h02);
      cmp(16'({int_en_hi, modem_ctl_hi}), 16'h57, "latched");
      cmp(16'(rts_n_pin), 16'h0, "software rts");
      $display("test enhanced done");
      host.wr(A_BANK_SEL, 8'h04);
      host.wr(A_FEATURE, 8'hc0);
      @(posedge core_clk);
      {cts_n_pin, rx_trig_level, rx_fifo_fill} <= {1'b1, 16'h0405};
      tick(4);
      cmp(16'({tx_halt, rts_n_pin}), 16'h3, "halt rts up");
      cts_n_pin <= 1'b0;
      rx_fifo_fill <= 8'h03;
      tick(4);
      cmp(16'({tx_halt, rts_n_pin}), 16'h1, "resume band");
      rx_fifo_fill <= 8'h02;
      tick(4);
      cmp(16'(rts_n_pin), 16'h0, "rts down");
      rx_fifo_fill <= 8'h04;
      $display("test hardware flow done");
      e = rnd() | 8'h01;
      host.wr(A_PAUSE_2, e);
      host.wr(A_FEATURE, 8'h20);
      rxc(e ^ 8'h01);
      cmp(16'(special_char_flag), 16'h0, "near miss");
      rxc(e);
      cmp(16'(special_char_flag), 16'h1, "special");
      $display("test special done");
      v = rnd();
      host.wr(A_PAUSE_1, v);
      host.wr(A_FEATURE, 8'h0c);
      @(posedge core_clk);
      send_pause <= 1'b1;
      @(posedge core_clk);
      send_pause <= 1'b0;
      tick(3);
      cmp({7'h0, tx_flow_valid, tx_flow_char}, {8'h1, v}, "stall");
      tx_flow_ready <= 1'b1;
      k = 0;
      repeat (8) begin
         @(posedge core_clk);
         if (tx_flow_valid === 1'b1 && tx_flow_ready === 1'b1) begin
            cmp(16'(tx_flow_char), 16'((k == 0) ? v : e),
                "pause pair");
            k++;
         end
      end
      cmp(k[15:0], 16'h0002, "pair count");
      $display("test software flow done");
      conclude();
   end
endmodule // uxr_ext_regs_bench

bind uxr_ext_regs uxr_ext_regs_chk chk_i (.*);
